/* File: verilog/coc_on_off_ctrl.sv */
// Channel on/off control: registers, initialization, input gate, channel sequencers
`timescale 1ns/1ps
`default_nettype none
module coc_on_off_ctrl #(
  parameter int INIT_CYCLES = coc_pkg::INIT_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  input  wire coc_pkg::coc_reg_req_s reg_req,
  output logic [7:0]                reg_rdata,
  output logic                      reg_rvalid,
  input  wire logic                 control_pin,
  input  wire logic                 vin_above_on,
  output logic                      init_done,
  output coc_pkg::coc_ch_out_s      ch_out [coc_pkg::NUM_CH]
);

  localparam int CW = $clog2(INIT_CYCLES + 1);

  typedef enum logic [1:0] {COC_SYS_INIT, COC_SYS_WAIT_VIN, COC_SYS_READY} coc_sys_e;
  typedef enum logic {COC_CH_OFF, COC_CH_ON} coc_ch_e;

  // True when a page value selects this channel, including the all-pages value
  function automatic logic page_hits(input logic [7:0] page, input int ch);
    return (page == coc_pkg::PAGE_ALL) || (page == 8'(ch));
  endfunction

  // Legal mode encodings; anything else is reserved and must not be stored
  function automatic logic opmode_legal(input logic [7:0] b, input logic use_bus);
    logic [1:0] c;
    logic [1:0] m;
    logic [1:0] f;
    c = b[coc_pkg::OP_CTRL_LSB +: 2];
    m = b[coc_pkg::OP_MARGIN_LSB +: 2];
    f = b[coc_pkg::OP_FAULT_LSB +: 2];
    if (b[1:0] != 2'h0 || c == 2'h3) begin
      return 1'b0;
    end
    if (use_bus && c == coc_pkg::CTRL_OFF_NOW) begin
      return 1'b1;
    end
    if (m == 2'h3) begin
      return 1'b0;
    end
    return (m == coc_pkg::MARGIN_NOM) || (f == coc_pkg::FAULT_IGNORE) ||
           (f == coc_pkg::FAULT_HONOR);
  endfunction

  // Pin and comparator inputs come from outside the clock domain
  logic ctrl_meta_ff;
  logic ctrl_ff;
  logic vin_meta_ff;
  logic vin_ff;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_meta_ff <= 1'b0;
      ctrl_ff      <= 1'b0;
      vin_meta_ff  <= 1'b0;
      vin_ff       <= 1'b0;
    end else begin
      ctrl_meta_ff <= control_pin;
      ctrl_ff      <= ctrl_meta_ff;
      vin_meta_ff  <= vin_above_on;
      vin_ff       <= vin_meta_ff;
    end
  end

  // Initialization and input supply gate
  coc_sys_e  sys_ff;
  coc_sys_e  nxt_sys;
  logic [CW-1:0] init_cnt_ff;
  logic [CW-1:0] nxt_init_cnt;

  always_comb begin
    nxt_sys      = sys_ff;
    nxt_init_cnt = init_cnt_ff;
    unique case (sys_ff)
      COC_SYS_INIT: begin
        if (init_cnt_ff == CW'(INIT_CYCLES - 1)) begin
          nxt_sys = COC_SYS_WAIT_VIN;
        end else begin
          nxt_init_cnt = init_cnt_ff + CW'(1);
        end
      end
      COC_SYS_WAIT_VIN: begin
        if (vin_ff) begin
          nxt_sys = COC_SYS_READY;
        end
      end
      // Once sequencing has begun a dip below threshold is left to the supervisors
      COC_SYS_READY: nxt_sys = COC_SYS_READY;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_ff      <= COC_SYS_INIT;
      init_cnt_ff <= '0;
    end else begin
      sys_ff      <= nxt_sys;
      init_cnt_ff <= nxt_init_cnt;
    end
  end

  assign init_done = (sys_ff != COC_SYS_INIT);

  // Registers
  logic [7:0]        opmode_ff [coc_pkg::NUM_CH];
  logic [7:0]        nxt_opmode [coc_pkg::NUM_CH];
  coc_pkg::coc_cfg_s cfg_ff [coc_pkg::NUM_CH];
  coc_pkg::coc_cfg_s nxt_cfg [coc_pkg::NUM_CH];
  logic [7:0]        nxt_rdata;
  logic              nxt_rvalid;
  logic              rd_ch;
  logic              rd_page_ok;

  assign rd_ch      = (reg_req.page == coc_pkg::PAGE_ALL) ? 1'b0 : reg_req.page[0];
  assign rd_page_ok = (reg_req.page == coc_pkg::PAGE_ALL) ||
                      (reg_req.page < 8'(coc_pkg::NUM_CH));

  always_comb begin
    for (int i = 0; i < coc_pkg::NUM_CH; i++) begin
      nxt_opmode[i] = opmode_ff[i];
      nxt_cfg[i]    = cfg_ff[i];
      if (reg_req.wr && page_hits(reg_req.page, i)) begin
        if (reg_req.code == coc_pkg::CMD_OPMODE &&
            opmode_legal(reg_req.wdata, cfg_ff[i].use_bus)) begin
          nxt_opmode[i] = reg_req.wdata;
        end
        if (reg_req.code == coc_pkg::CMD_ONOFF) begin
          nxt_cfg[i].controlled_on = reg_req.wdata[coc_pkg::CFG_CONTROLLED_ON];
          nxt_cfg[i].use_bus       = reg_req.wdata[coc_pkg::CFG_USE_BUS];
          nxt_cfg[i].use_pin       = reg_req.wdata[coc_pkg::CFG_USE_PIN];
          nxt_cfg[i].fast_off      = reg_req.wdata[coc_pkg::CFG_FAST_OFF];
        end
      end
    end
    nxt_rvalid = reg_req.rd;
    nxt_rdata  = 8'h00;
    if (reg_req.rd && rd_page_ok) begin
      if (reg_req.code == coc_pkg::CMD_OPMODE) begin
        nxt_rdata = {opmode_ff[rd_ch][7:2], 2'h0};
      end else if (reg_req.code == coc_pkg::CMD_ONOFF) begin
        nxt_rdata = {3'h0, cfg_ff[rd_ch].controlled_on, cfg_ff[rd_ch].use_bus,
                     cfg_ff[rd_ch].use_pin, 1'b1, cfg_ff[rd_ch].fast_off};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < coc_pkg::NUM_CH; i++) begin
        opmode_ff[i]            <= coc_pkg::OPMODE_RST;
        cfg_ff[i].controlled_on <= coc_pkg::ONOFF_RST[coc_pkg::CFG_CONTROLLED_ON];
        cfg_ff[i].use_bus       <= coc_pkg::ONOFF_RST[coc_pkg::CFG_USE_BUS];
        cfg_ff[i].use_pin       <= coc_pkg::ONOFF_RST[coc_pkg::CFG_USE_PIN];
        cfg_ff[i].fast_off      <= coc_pkg::ONOFF_RST[coc_pkg::CFG_FAST_OFF];
      end
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      for (int i = 0; i < coc_pkg::NUM_CH; i++) begin
        opmode_ff[i] <= nxt_opmode[i];
        cfg_ff[i]    <= nxt_cfg[i];
      end
      reg_rdata  <= nxt_rdata;
      reg_rvalid <= nxt_rvalid;
    end
  end

  a_cfg_read_fixed: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.code == coc_pkg::CMD_ONOFF && rd_page_ok
    |=> reg_rvalid && reg_rdata[7:5] == 3'h0 && reg_rdata[1])
    else $error("on/off config readback fixed bits wrong");

  a_mode_low_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_req.rd && reg_req.code == coc_pkg::CMD_OPMODE |=> reg_rdata[1:0] == 2'h0)
    else $error("operating mode low bits not zero");

  a_global_cfg: assert property (@(posedge core_clk) disable iff (!rst_b)
    reg_req.wr && reg_req.code == coc_pkg::CMD_ONOFF && reg_req.page == coc_pkg::PAGE_ALL
    |=> cfg_ff[0] == cfg_ff[1] &&
        cfg_ff[0].use_pin == $past(reg_req.wdata[coc_pkg::CFG_USE_PIN]))
    else $error("all-pages config write missed a channel");

  a_init_len: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(init_done) |-> $past(init_cnt_ff) == CW'(INIT_CYCLES - 1))
    else $error("initialization ended early");

  // Channel sequencers
  for (genvar g = 0; g < coc_pkg::NUM_CH; g++) begin : gen_ch
    logic                 want_on;
    coc_pkg::coc_off_e    off_mode;
    logic [1:0]           margin;
    logic                 ignore_faults;
    coc_ch_e              st_ff;
    coc_ch_e              nxt_st;
    coc_pkg::coc_ch_out_s out_ff;
    coc_pkg::coc_ch_out_s nxt_out;

    coc_ch_decide u_decide (
      .cfg           (cfg_ff[g]),
      .opmode        (opmode_ff[g]),
      .pin_on        (ctrl_ff),
      .want_on       (want_on),
      .off_mode      (off_mode),
      .margin        (margin),
      .ignore_faults (ignore_faults)
    );

    always_comb begin
      nxt_st                = st_ff;
      nxt_out               = out_ff;
      nxt_out.on_start      = 1'b0;
      nxt_out.off_start     = 1'b0;
      nxt_out.margin        = margin;
      nxt_out.ignore_faults = ignore_faults;
      unique case (st_ff)
        COC_CH_OFF: begin
          if (want_on && sys_ff == COC_SYS_READY) begin
            nxt_st           = COC_CH_ON;
            nxt_out.run      = 1'b1;
            nxt_out.on_start = 1'b1;
          end
        end
        COC_CH_ON: begin
          if (!want_on) begin
            nxt_st            = COC_CH_OFF;
            nxt_out.run       = 1'b0;
            nxt_out.off_start = 1'b1;
            nxt_out.off_mode  = off_mode;
          end
        end
      endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
        st_ff  <= COC_CH_OFF;
        out_ff <= '{run: 1'b0, on_start: 1'b0, off_start: 1'b0,
                    off_mode: coc_pkg::COC_OFF_SEQ, margin: 2'h0, ignore_faults: 1'b0};
      end else begin
        st_ff  <= nxt_st;
        out_ff <= nxt_out;
      end
    end

    assign ch_out[g] = out_ff;

    a_start_gated: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_ff.on_start |-> $past(sys_ff) == COC_SYS_READY && $past(vin_ff, 2) | init_done)
      else $error("channel started before init and input threshold");

    a_never_up: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(out_ff.run) |-> !($past(cfg_ff[g].controlled_on) &&
                              !$past(cfg_ff[g].use_pin) && !$past(cfg_ff[g].use_bus)))
      else $error("channel powered up with no source selected");

    a_auto_up: assert property (@(posedge core_clk) disable iff (!rst_b)
      sys_ff == COC_SYS_READY && !cfg_ff[g].controlled_on |-> ##[0:1] out_ff.run)
      else $error("uncontrolled channel did not power up");

    a_pin_and_bus: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(out_ff.run) && $past(cfg_ff[g].controlled_on) && $past(cfg_ff[g].use_pin) &&
      $past(cfg_ff[g].use_bus)
      |-> $past(ctrl_ff) &&
          $past(opmode_ff[g][coc_pkg::OP_CTRL_LSB +: 2]) == coc_pkg::CTRL_SEQ_ON)
      else $error("channel started without both pin and bus");

    a_fast_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_ff.off_start && out_ff.off_mode == coc_pkg::COC_OFF_FAST
      |-> $past(cfg_ff[g].fast_off) && !$past(ctrl_ff))
      else $error("fast off without pin turn-off and fast bit");

    a_bus_off_now: assert property (@(posedge core_clk) disable iff (!rst_b)
      st_ff == COC_CH_ON && cfg_ff[g].use_bus && cfg_ff[g].controlled_on &&
      opmode_ff[g][coc_pkg::OP_CTRL_LSB +: 2] == coc_pkg::CTRL_OFF_NOW
      |=> out_ff.off_start && out_ff.off_mode == coc_pkg::COC_OFF_NOW && !out_ff.run)
      else $error("bus immediate off not honoured");
  end

endmodule // coc_on_off_ctrl
`default_nettype wire

/* File: verilog/coc_pkg.sv */
// Constants and types for the channel on/off control block
// Overview of operation
// - Without bus control, margin and fault fields set target
// - All-pages selector writes configuration to both channels
// - No sequencing until input threshold is exceeded
// - Initialization interval precedes turn-on delay timer
// - Config top three bits ignored, read zero
// - Uncontrolled power-up always turns on with sequencing
// - Controlled power-up needs sources; none means never
// - Bus-select bit decides whether bus command counts
// - Pin-select bit decides whether pin is required
// - Both selected: pin and bus both required
// - Config bit one reads one on a channel page; a read of a page past the channels returns all zeros
// - Fast-off bit picks pin turn-off behaviour
// - Bus field: 00 off now, 10 on, 01 off
package coc_pkg;

  localparam int NUM_CH = 2;

  // Command codes and the page value that addresses every channel
  localparam logic [7:0] CMD_OPMODE = 8'h01;
  localparam logic [7:0] CMD_ONOFF  = 8'h02;
  localparam logic [7:0] PAGE_ALL   = 8'hFF;

  localparam logic [7:0] OPMODE_RST = 8'h00;
  localparam logic [7:0] ONOFF_RST  = 8'h12;

  // Operating-mode byte fields
  localparam int OP_CTRL_LSB   = 6;
  localparam int OP_MARGIN_LSB = 4;
  localparam int OP_FAULT_LSB  = 2;

  // On/off configuration byte fields
  localparam int CFG_CONTROLLED_ON = 4;
  localparam int CFG_USE_BUS       = 3;
  localparam int CFG_USE_PIN       = 2;
  localparam int CFG_FAST_OFF      = 0;

  localparam logic [1:0] CTRL_OFF_NOW = 2'h0;
  localparam logic [1:0] CTRL_SEQ_OFF = 2'h1;
  localparam logic [1:0] CTRL_SEQ_ON  = 2'h2;
  localparam logic [1:0] MARGIN_NOM   = 2'h0;
  localparam logic [1:0] MARGIN_LOW   = 2'h1;
  localparam logic [1:0] MARGIN_HIGH  = 2'h2;
  localparam logic [1:0] FAULT_IGNORE = 2'h1;
  localparam logic [1:0] FAULT_HONOR  = 2'h2;

  // Initialization interval
  localparam int T_INIT_NS     = 10000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int INIT_CYCLES   = (T_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {COC_OFF_SEQ, COC_OFF_FAST, COC_OFF_NOW} coc_off_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] code;
    logic [7:0] wdata;
  } coc_reg_req_s;

  typedef struct packed {
    logic controlled_on;
    logic use_bus;
    logic use_pin;
    logic fast_off;
  } coc_cfg_s;

  typedef struct packed {
    logic       run;
    logic       on_start;
    logic       off_start;
    coc_off_e   off_mode;
    logic [1:0] margin;
    logic       ignore_faults;
  } coc_ch_out_s;

endpackage

/* File: verilog/coc_ch_decide.sv */
// Per-channel decision: wanted on state, turn-off kind and voltage target
`timescale 1ns/1ps
`default_nettype none
module coc_ch_decide (
  input  wire coc_pkg::coc_cfg_s cfg,
  input  wire logic [7:0]        opmode,
  input  wire logic              pin_on,
  output logic                   want_on,
  output coc_pkg::coc_off_e      off_mode,
  output logic [1:0]             margin,
  output logic                   ignore_faults
);

  logic [1:0] ctrl;
  logic       bus_on;

  assign ctrl   = opmode[coc_pkg::OP_CTRL_LSB +: 2];
  assign bus_on = cfg.use_bus && (ctrl == coc_pkg::CTRL_SEQ_ON);

  always_comb begin
    if (!cfg.controlled_on) begin
      want_on = 1'b1;
    end else begin
      unique case ({cfg.use_pin, cfg.use_bus})
        2'b00: want_on = 1'b0;
        2'b01: want_on = bus_on;
        2'b10: want_on = pin_on;
        2'b11: want_on = pin_on && bus_on;
      endcase
    end
  end

  always_comb begin
    if (cfg.use_bus && ctrl == coc_pkg::CTRL_OFF_NOW) begin
      off_mode = coc_pkg::COC_OFF_NOW;
    end else if (cfg.use_pin && !pin_on) begin
      off_mode = cfg.fast_off ? coc_pkg::COC_OFF_FAST : coc_pkg::COC_OFF_SEQ;
    end else begin
      off_mode = coc_pkg::COC_OFF_SEQ;
    end
  end

  // Margin field is don't-care under an immediate bus off
  always_comb begin
    if (cfg.use_bus && ctrl == coc_pkg::CTRL_OFF_NOW) begin
      margin        = coc_pkg::MARGIN_NOM;
      ignore_faults = 1'b0;
    end else begin
      margin        = opmode[coc_pkg::OP_MARGIN_LSB +: 2];
      ignore_faults = (margin != coc_pkg::MARGIN_NOM) &&
                      (opmode[coc_pkg::OP_FAULT_LSB +: 2] == coc_pkg::FAULT_IGNORE);
    end
  end

endmodule // coc_ch_decide
`default_nettype wire

/* File: testbench/coc_host_model.sv */
// Behavioural bus host and control-pin driver facing the on/off block
`timescale 1ns/1ps
`default_nettype none
module coc_host_model #(
  parameter int OFF_MIN_CYC = 16
) (
  input  wire logic              core_clk,
  input  wire logic [7:0]        reg_rdata,
  input  wire logic              reg_rvalid,
  output coc_pkg::coc_reg_req_s  reg_req,
  output logic                   control_pin,
  output logic                   vin_above_on
);
  int cyc = 0;
  int pin_off_at = -1000;
  int bus_off_at = -1000;

  always @(posedge core_clk) cyc <= cyc + 1;

  initial begin
    reg_req = '0;
    control_pin = 1'b0;
    vin_above_on = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] page, input logic [7:0] code,
                      input logic [7:0] wdata, output logic [7:0] rdata);
    @(posedge core_clk);
    #1;
    reg_req.wr = w;
    reg_req.rd = !w;
    reg_req.page = page;
    reg_req.code = code;
    reg_req.wdata = wdata;
    @(posedge core_clk);
    #1;
    rdata = (!w && reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    // Released lines flip so stale values cannot pass for live ones
    reg_req.page = ~page;
    reg_req.code = ~code;
    reg_req.wdata = ~wdata;
  endtask

  task automatic write_reg(input logic [7:0] page, input logic [7:0] code,
                           input logic [7:0] wdata);
    logic [7:0] dummy;
    if (code == coc_pkg::CMD_OPMODE && wdata[7:6] == coc_pkg::CTRL_SEQ_ON) begin
      while (cyc - bus_off_at < OFF_MIN_CYC) @(posedge core_clk);
    end
    if (code == coc_pkg::CMD_OPMODE && wdata[7] == 1'b0) bus_off_at = cyc + 2;
    xfer(1'b1, page, code, wdata, dummy);
  endtask

  task automatic read_reg(input logic [7:0] page, input logic [7:0] code,
                          output logic [7:0] rdata);
    xfer(1'b0, page, code, 8'h00, rdata);
  endtask

  task automatic set_pin(input logic v);
    if (v && !control_pin) begin
      while (cyc - pin_off_at < OFF_MIN_CYC) @(posedge core_clk);
    end
    @(posedge core_clk);
    #1;
    if (!v && control_pin) pin_off_at = cyc;
    control_pin = v;
  endtask

  task automatic set_vin(input logic v);
    @(posedge core_clk);
    #1;
    vin_above_on = v;
  endtask
endmodule // coc_host_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the channel on/off control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] CFG = coc_pkg::CMD_ONOFF;
  localparam logic [7:0] OPM = coc_pkg::CMD_OPMODE;
  localparam logic [7:0] ALL = coc_pkg::PAGE_ALL;

  typedef struct {
    logic [7:0] code;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [1:0] mexp;
    logic       iexp;
  } coc_row_s;

  coc_row_s rows [9] = '{
    '{CFG, 8'hE0, 8'h02, 2'h0, 1'b0}, '{CFG, 8'h1D, 8'h1F, 2'h0, 1'b0},
    '{CFG, 8'h12, 8'h12, 2'h0, 1'b0}, '{OPM, 8'h94, 8'h94, 2'h1, 1'b1},
    '{OPM, 8'h97, 8'h94, 2'h1, 1'b1}, '{OPM, 8'hB4, 8'h94, 2'h1, 1'b1},
    '{OPM, 8'h60, 8'h94, 2'h1, 1'b1}, '{OPM, 8'hE8, 8'h94, 2'h1, 1'b1},
    '{OPM, 8'h68, 8'h68, 2'h2, 1'b0}};

  logic                  core_clk;
  logic                  rst_b;
  coc_pkg::coc_reg_req_s reg_req;
  logic [7:0]            reg_rdata;
  logic                  reg_rvalid;
  logic                  control_pin;
  logic                  vin_above_on;
  logic                  init_done;
  coc_pkg::coc_ch_out_s  ch_out [coc_pkg::NUM_CH];
  int                    mismatches = 0;
  int                    checked = 0;
  int                    on_cnt = 0;
  int                    off_cnt = 0;

  coc_on_off_ctrl #(.INIT_CYCLES(8)) coc_on_off_ctrl_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .control_pin(control_pin), .vin_above_on(vin_above_on),
    .init_done(init_done), .ch_out(ch_out));

  coc_host_model coc_host_model_i (
    .core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_req(reg_req), .control_pin(control_pin), .vin_above_on(vin_above_on));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk) if (ch_out[0].on_start === 1'b1) on_cnt++;
  always @(posedge core_clk) if (ch_out[1].off_start === 1'b1) off_cnt++;

  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_byte(name, {7'h00, exp}, {7'h00, got});
  endtask

  task automatic chk_off(input coc_pkg::coc_off_e exp, input coc_pkg::coc_off_e got);
    chk_byte("off_mode", {6'h00, exp}, {6'h00, got});
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] c, input logic [7:0] d);
    coc_host_model_i.write_reg(p, c, d);
  endtask

  task automatic rd_chk(input logic [7:0] p, input logic [7:0] c, input logic [7:0] exp);
    logic [7:0] v;
    coc_host_model_i.read_reg(p, c, v);
    chk_byte("reg_rdata", exp, v);
  endtask

  // Hold mode waits the full span so a late wrong turn-on or turn-off is still caught
  task automatic run_is(input logic v, input logic hold);
    int n;
    n = 0;
    while (n < 8 && (hold || ch_out[0].run !== v || ch_out[1].run !== v)) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_bit("run0", v, ch_out[0].run);
    chk_bit("run1", v, ch_out[1].run);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    rst_b = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bit("init_done", 1'b0, init_done);
    repeat (6) @(posedge core_clk);
    #1;
    chk_bit("init_done", 1'b1, init_done);
    rd_chk(8'h00, CFG, 8'h12);
    rd_chk(8'h01, OPM, 8'h00);
    wr(ALL, CFG, 8'h00);
    run_is(1'b0, 1'b1);
    coc_host_model_i.set_vin(1'b1);
    run_is(1'b1, 1'b0);
    // The pulse counter only sees on_start one edge after run rises
    @(posedge core_clk);
    #1;
    chk_byte("on_start", 8'h01, on_cnt[7:0]);
    wr(ALL, CFG, 8'h16);
    run_is(1'b0, 1'b0);
    coc_host_model_i.set_pin(1'b1);
    run_is(1'b1, 1'b0);
    coc_host_model_i.set_pin(1'b0);
    run_is(1'b0, 1'b0);
    chk_off(coc_pkg::COC_OFF_SEQ, ch_out[0].off_mode);
    // One turn-off from the config change, one from the pin
    @(posedge core_clk);
    #1;
    chk_byte("off_start", 8'h02, off_cnt[7:0]);
    wr(ALL, CFG, 8'h17);
    coc_host_model_i.set_pin(1'b1);
    run_is(1'b1, 1'b0);
    coc_host_model_i.set_pin(1'b0);
    run_is(1'b0, 1'b0);
    chk_off(coc_pkg::COC_OFF_FAST, ch_out[1].off_mode);
    wr(ALL, CFG, 8'h1A);
    wr(ALL, OPM, 8'h80);
    run_is(1'b1, 1'b0);
    wr(ALL, OPM, 8'h40);
    run_is(1'b0, 1'b0);
    chk_off(coc_pkg::COC_OFF_SEQ, ch_out[0].off_mode);
    wr(ALL, OPM, 8'h80);
    run_is(1'b1, 1'b0);
    wr(ALL, OPM, 8'h00);
    run_is(1'b0, 1'b0);
    chk_off(coc_pkg::COC_OFF_NOW, ch_out[0].off_mode);
    wr(ALL, CFG, 8'h1E);
    wr(ALL, OPM, 8'h80);
    run_is(1'b0, 1'b1);
    coc_host_model_i.set_pin(1'b1);
    run_is(1'b1, 1'b0);
    wr(ALL, CFG, 8'h12);
    run_is(1'b0, 1'b1);
    wr(ALL, CFG, 8'h16);
    wr(ALL, OPM, 8'h00);
    run_is(1'b1, 1'b1);
    foreach (rows[i]) begin
      wr(ALL, rows[i].code, rows[i].wdata);
      rd_chk(8'h00, rows[i].code, rows[i].rexp);
      rd_chk(8'h01, rows[i].code, rows[i].rexp);
      chk_byte("margin", {6'h00, rows[i].mexp}, {6'h00, ch_out[1].margin});
      chk_bit("ignore_faults", rows[i].iexp, ch_out[0].ignore_faults);
    end
    wr(8'h01, OPM, 8'h94);
    rd_chk(8'h00, OPM, 8'h68);
    rd_chk(8'h01, OPM, 8'h94);
    wr(8'h00, 8'h05, 8'h55);
    rd_chk(8'h00, 8'h05, 8'h00);
    rd_chk(8'h02, CFG, 8'h00);
    wr(ALL, CFG, 8'h00);
    run_is(1'b1, 1'b0);
    // A dip after sequencing has begun is left to the supervisors
    coc_host_model_i.set_vin(1'b0);
    run_is(1'b1, 1'b1);
    coc_host_model_i.set_vin(1'b1);
    // Mid-run reset with the supply already high: only the init interval holds the start
    @(posedge core_clk);
    #1;
    rst_b = 1'b0;
    #1;
    chk_bit("run0", 1'b0, ch_out[0].run);
    repeat (2) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    rd_chk(8'h01, CFG, 8'h12);
    wr(ALL, CFG, 8'h00);
    chk_bit("run1", 1'b0, ch_out[1].run);
    repeat (2) @(posedge core_clk);
    #1;
    chk_bit("init_done", 1'b0, init_done);
    chk_bit("run0", 1'b0, ch_out[0].run);
    run_is(1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
